// >>> pkg/fucc_pkg.sv
// Constants for the flash unlock command controller
package fucc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [13:0] IDX_CMD    = 14'hFF8;
   localparam logic [13:0] IDX_PSEL   = 14'hFF9;
   localparam logic [13:0] IDX_FREQH  = 14'hFFA;
   localparam logic [13:0] IDX_FREQL  = 14'hFFB;
   localparam logic [13:0] IDX_LOT    = 14'hE00;
   localparam int          LOT_BYTES  = 32;
   // Command codes
   localparam logic [7:0]  CMD_UNLK1  = 8'h73;
   localparam logic [7:0]  CMD_UNLK2  = 8'h8C;
   localparam logic [7:0]  CMD_PERASE = 8'h95;
   localparam logic [7:0]  CMD_MERASE = 8'h63;
   localparam logic [7:0]  CMD_SECT   = 8'h5E;
   // Status codes, bits [5:0]
   localparam logic [5:0]  ST_LOCKED  = 6'h00;
   localparam logic [5:0]  ST_FIRST   = 6'h01;
   localparam logic [5:0]  ST_SECOND  = 6'h02;
   localparam logic [5:0]  ST_OPEN    = 6'h03;
   localparam logic [5:0]  ST_SECTSEL = 6'h04;
   localparam logic [5:0]  ST_PROG    = 6'h08;
   localparam logic [5:0]  ST_PERASE  = 6'h10;
   localparam logic [5:0]  ST_MERASE  = 6'h20;
   // Field layout and reset values
   localparam int          PS_INFO_BIT = 7;
   localparam int          PAGE_LSB    = 9;
   localparam logic [7:0]  REG_RST     = 8'h00;
   localparam logic [6:0]  INFO_PAGE   = 7'h7F;
   // Operation times in ms; cycles = freq_khz * ms
   localparam logic [7:0]  PROG_MS     = 8'h01;
   localparam logic [7:0]  PERASE_MS   = 8'h0A;
   localparam logic [7:0]  MERASE_MS   = 8'h0A;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [7:0] {
      FS_LOCKED = 8'h01,
      FS_FIRST  = 8'h02,
      FS_SECOND = 8'h04,
      FS_OPEN   = 8'h08,
      FS_SECT   = 8'h10,
      FS_PROG   = 8'h20,
      FS_PERASE = 8'h40,
      FS_MERASE = 8'h80
   } fucc_state_t;
endpackage

// >>> pkg/fucc_op_if.sv
// Handshake between the controller and its operation timer
`timescale 1ns/10ps
interface fucc_op_if;
   logic        start;
   logic [23:0] cycles;
   logic        done;
   logic        busy;
   modport ctrl (output start, output cycles, input done, input busy);
   modport tmr  (input start, input cycles, output done, output busy);
endinterface

// >>> hw/fucc_op_timer.sv
// Operation timer that paces program and erase runs
`timescale 1ns/10ps
module fucc_op_timer (
   input  wire logic aclk,
   input  wire logic aresetn,
   fucc_op_if.tmr    op
);
   logic [23:0] cnt_q;
   logic        busy_q;
   logic        done_q;

   assign op.busy = busy_q;
   assign op.done = done_q;

   // Load on start, count down, one-cycle done at the end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q  <= 24'h000000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (op.start && !busy_q) begin
            busy_q <= 1'b1;
            // Zero frequency would never finish; run one cycle
            cnt_q  <= (op.cycles == 24'h000000) ? 24'h000001 : op.cycles;
         end else if (busy_q) begin
            if (cnt_q == 24'h000001) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 24'h000001;
            end
         end
      end
   end
endmodule

// >>> hw/fucc_top.sv
// Flash unlock command controller with AXI4-Lite registers
// Function
// [RULE_01] Codes 73h then 8Ch advance the unlock state one step each.
// [RULE_02] Page erase starts only on 95h as third command.
// [RULE_03] Mass erase starts only on 63h as third command.
// [RULE_04] 5Eh while unlocked selects sector protect at page-select address.
// [RULE_05] Command write-only, status read-only, one shared address.
// [RULE_06] Status reads 0,1,2,3 for locked, first, second, unlocked.
// [RULE_07] Status reads 000100 while sector protect is selected.
// [RULE_08] Upper status bits 001, 010, 100 for program, page, mass erase.
// [RULE_09] Status bits 7:6 reset to zero and stay zero.
// [RULE_10] Page-select writes go to sector protect only after 5Eh unlocked.
// [RULE_11] Pages are 512 bytes; address bits 15:9 match page field.
// [RULE_12] Info enable maps info area at FE00h to FFFFh.
// [RULE_13] Software keeps unused upper page bits zero on small parts.
// [RULE_14] High and low frequency bytes form the 16-bit timing value.
// [RULE_15] Software avoids program or erase outside 20 kHz to 20 MHz.
// [RULE_16] Information page holds a 32-byte lot identifier.
// [RULE_17] Reset leaves the lot identifier bytes unchanged.
// [RULE_18] Software loads the clock frequency in kHz.
// [RULE_19] Any out-of-sequence command write returns to locked; the code ignores command writes during program and erase runs.
// [RULE_20] After an erase finishes the controller leaves the busy code.
`timescale 1ns/10ps
module fucc_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        prog_req,
   input  wire logic [15:0] prog_addr,
   output logic             program_active,
   output logic             page_erase_active,
   output logic             mass_erase_active,
   output logic [6:0]       erase_page,
   output logic             page_hit,
   output logic             info_area_sel,
   output logic [15:0]      timing_freq_value,
   output logic [7:0]       sector_protect
);
   fucc_op_if op ();

   fucc_op_timer u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .op      (op)
   );

   fucc_pkg::fucc_state_t state_q;
   fucc_pkg::fucc_state_t state_d;
   logic [15:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        aw_have_q;
   logic        w_have_q;
   logic        awready_q;
   logic        wready_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [1:0]  rresp_q;
   logic [31:0] rdata_q;
   logic [7:0]  psel_q;
   logic [7:0]  sect_q;
   logic [7:0]  freqh_q;
   logic [7:0]  freql_q;
   logic [7:0]  lot_mem [fucc_pkg::LOT_BYTES];
   logic        op_start_q;
   logic [23:0] op_cycles_q;
   logic [3:0]  flags_q;
   logic        hit_q;
   logic        info_q;
   logic        wr_fire;
   logic [13:0] wr_idx;
   logic [13:0] rd_idx;
   logic        wr_lane;
   logic [7:0]  wr_byte;
   logic        cmd_wr;
   logic        ps_wr;
   logic        start_prog;
   logic        start_pe;
   logic        start_me;

   // Register index from a byte address
   function automatic logic [13:0] reg_idx(input logic [15:0] a);
      return a[15:2];
   endfunction

   // True when an index falls in the lot identifier window
   function automatic logic lot_hit(input logic [13:0] i);
      return i >= fucc_pkg::IDX_LOT &&
             i < fucc_pkg::IDX_LOT + 14'(fucc_pkg::LOT_BYTES);
   endfunction

   // Six-bit status code for each controller state
   function automatic logic [5:0] code_of(input fucc_pkg::fucc_state_t s);
      logic [5:0] c;
      c = fucc_pkg::ST_LOCKED;
      unique case (s)
         fucc_pkg::FS_LOCKED: c = fucc_pkg::ST_LOCKED;
         fucc_pkg::FS_FIRST:  c = fucc_pkg::ST_FIRST;
         fucc_pkg::FS_SECOND: c = fucc_pkg::ST_SECOND;
         fucc_pkg::FS_OPEN:   c = fucc_pkg::ST_OPEN;
         fucc_pkg::FS_SECT:   c = fucc_pkg::ST_SECTSEL;
         fucc_pkg::FS_PROG:   c = fucc_pkg::ST_PROG;
         fucc_pkg::FS_PERASE: c = fucc_pkg::ST_PERASE;
         fucc_pkg::FS_MERASE: c = fucc_pkg::ST_MERASE;
         default:             c = fucc_pkg::ST_LOCKED;
      endcase
      return c;
   endfunction

   assign s_axi_awready     = awready_q;
   assign s_axi_wready      = wready_q;
   assign s_axi_bvalid      = bvalid_q;
   assign s_axi_bresp       = bresp_q;
   assign s_axi_arready     = arready_q;
   assign s_axi_rvalid      = rvalid_q;
   assign s_axi_rresp       = rresp_q;
   assign s_axi_rdata       = rdata_q;
   assign program_active    = flags_q[0];
   assign page_erase_active = flags_q[1];
   assign mass_erase_active = flags_q[2];
   assign erase_page        = psel_q[6:0];
   assign page_hit          = hit_q;
   assign info_area_sel     = info_q;
   assign timing_freq_value = {freqh_q, freql_q}; // [RULE_14]
   assign sector_protect    = sect_q;

   // Write decode; byte lane 0 carries the 8-bit registers
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign wr_idx  = reg_idx(aw_addr_q);
   assign rd_idx  = reg_idx(s_axi_araddr);
   assign wr_lane = wr_fire && w_strb_q[0];
   assign wr_byte = w_data_q[7:0];
   assign cmd_wr  = wr_lane && wr_idx == fucc_pkg::IDX_CMD; // [RULE_05]
   assign ps_wr   = wr_lane && wr_idx == fucc_pkg::IDX_PSEL;

   // Operation starts, each only from its proper state
   assign start_pe = state_q == fucc_pkg::FS_SECOND && cmd_wr &&
                     wr_byte == fucc_pkg::CMD_PERASE; // [RULE_02]
   assign start_me = state_q == fucc_pkg::FS_SECOND && cmd_wr &&
                     wr_byte == fucc_pkg::CMD_MERASE; // [RULE_03]
   assign start_prog = state_q == fucc_pkg::FS_OPEN && prog_req && !cmd_wr;

   // AXI write address and data, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_addr_q <= 16'h0000;
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_q) begin
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
         end
         // Reopen only after the response is taken; one write at a time
         if (bvalid_q && s_axi_bready) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // Write response; unmapped indices answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= fucc_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wr_idx >= fucc_pkg::IDX_CMD &&
                      wr_idx <= fucc_pkg::IDX_FREQL) || lot_hit(wr_idx) ?
                     fucc_pkg::RESP_OKAY : fucc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read channel; status readable any time, reserved bits zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rresp_q   <= fucc_pkg::RESP_OKAY;
         rdata_q   <= 32'h00000000;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= fucc_pkg::RESP_OKAY;
         rdata_q   <= 32'h00000000;
         if (rd_idx == fucc_pkg::IDX_CMD) begin
            rdata_q[7:0] <= {2'b00, code_of(state_q)}; // [RULE_05] [RULE_09]
         end else if (rd_idx == fucc_pkg::IDX_PSEL) begin
            rdata_q[7:0] <= state_q == fucc_pkg::FS_SECT ? sect_q : psel_q;
         end else if (rd_idx == fucc_pkg::IDX_FREQH) begin
            rdata_q[7:0] <= freqh_q;
         end else if (rd_idx == fucc_pkg::IDX_FREQL) begin
            rdata_q[7:0] <= freql_q;
         end else if (lot_hit(rd_idx)) begin
            rdata_q[7:0] <= lot_mem[rd_idx[4:0]]; // [RULE_16]
         end else begin
            rresp_q <= fucc_pkg::RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // Unlock sequence and operation state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         fucc_pkg::FS_LOCKED: begin
            if (cmd_wr && wr_byte == fucc_pkg::CMD_UNLK1)
               state_d = fucc_pkg::FS_FIRST; // [RULE_01]
         end
         fucc_pkg::FS_FIRST: begin
            if (cmd_wr && wr_byte == fucc_pkg::CMD_UNLK2)
               state_d = fucc_pkg::FS_SECOND; // [RULE_01]
            else if (cmd_wr)
               state_d = fucc_pkg::FS_LOCKED; // [RULE_19]
         end
         fucc_pkg::FS_SECOND: begin
            if (start_pe)
               state_d = fucc_pkg::FS_PERASE; // [RULE_02]
            else if (start_me)
               state_d = fucc_pkg::FS_MERASE; // [RULE_03]
            else if (cmd_wr)
               state_d = fucc_pkg::FS_LOCKED; // [RULE_19]
            else if (ps_wr)
               state_d = fucc_pkg::FS_OPEN; // Page select completes unlock
         end
         fucc_pkg::FS_OPEN: begin
            if (cmd_wr && wr_byte == fucc_pkg::CMD_SECT)
               state_d = fucc_pkg::FS_SECT; // [RULE_04]
            else if (cmd_wr)
               state_d = fucc_pkg::FS_LOCKED; // [RULE_19]
            else if (start_prog)
               state_d = fucc_pkg::FS_PROG;
         end
         fucc_pkg::FS_SECT: begin
            if (cmd_wr && wr_byte != fucc_pkg::CMD_SECT)
               state_d = fucc_pkg::FS_LOCKED; // [RULE_19]
         end
         fucc_pkg::FS_PROG: begin
            if (op.done)
               state_d = fucc_pkg::FS_OPEN;
         end
         fucc_pkg::FS_PERASE, fucc_pkg::FS_MERASE: begin
            // Commands are ignored while busy
            if (op.done)
               state_d = fucc_pkg::FS_LOCKED; // [RULE_20]
         end
         default: state_d = fucc_pkg::FS_LOCKED;
      endcase
   end

   // State and the activity flags that follow it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= fucc_pkg::FS_LOCKED;
         flags_q <= 4'h0;
      end else begin
         state_q <= state_d;
         flags_q <= {1'b0,
                     state_d == fucc_pkg::FS_MERASE,
                     state_d == fucc_pkg::FS_PERASE,
                     state_d == fucc_pkg::FS_PROG}; // [RULE_08]
      end
   end

   // Timer launch; duration scales with the kHz value [RULE_14]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_start_q  <= 1'b0;
         op_cycles_q <= 24'h000000;
      end else begin
         op_start_q <= start_pe || start_me || start_prog;
         if (start_pe)
            op_cycles_q <= {freqh_q, freql_q} * fucc_pkg::PERASE_MS;
         else if (start_me)
            op_cycles_q <= {freqh_q, freql_q} * fucc_pkg::MERASE_MS;
         else if (start_prog)
            op_cycles_q <= {freqh_q, freql_q} * fucc_pkg::PROG_MS;
      end
   end

   assign op.start  = op_start_q;
   assign op.cycles = op_cycles_q;

   // Page select or sector protect, by unlock state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         psel_q <= fucc_pkg::REG_RST;
         sect_q <= fucc_pkg::REG_RST;
      end else if (ps_wr) begin
         if (state_q == fucc_pkg::FS_SECT)
            sect_q <= wr_byte; // [RULE_04] [RULE_10]
         else
            psel_q <= wr_byte; // [RULE_10]
      end
   end

   // Frequency bytes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         freqh_q <= fucc_pkg::REG_RST;
         freql_q <= fucc_pkg::REG_RST;
      end else begin
         if (wr_lane && wr_idx == fucc_pkg::IDX_FREQH)
            freqh_q <= wr_byte; // [RULE_14]
         if (wr_lane && wr_idx == fucc_pkg::IDX_FREQL)
            freql_q <= wr_byte;
      end
   end

   // Lot identifier store; no reset so the bytes survive it
   always_ff @(posedge aclk) begin
      if (wr_lane && lot_hit(wr_idx))
         lot_mem[wr_idx[4:0]] <= wr_byte; // [RULE_16] [RULE_17]
   end

   // Address decode toward the array
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit_q  <= 1'b0;
         info_q <= 1'b0;
      end else begin
         hit_q  <= prog_addr[15:fucc_pkg::PAGE_LSB] ==
                   psel_q[6:0]; // [RULE_11]
         info_q <= psel_q[fucc_pkg::PS_INFO_BIT] && // [RULE_12]
                   prog_addr[15:fucc_pkg::PAGE_LSB] == fucc_pkg::INFO_PAGE;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Writes land at least three cycles apart, so none fits between
   sequence seq_two_codes;
      cmd_wr && wr_byte == fucc_pkg::CMD_UNLK1 ##[1:5]
      cmd_wr && wr_byte == fucc_pkg::CMD_UNLK2;
   endsequence

   a_unlock_order: assert property ( // [RULE_01] [RULE_06]
      state_q == fucc_pkg::FS_LOCKED ##0 seq_two_codes
      |=> code_of(state_q) == fucc_pkg::ST_SECOND)
      else $error("unlock codes did not reach second step");
   a_page_erase_go: assert property ( // [RULE_02] [RULE_08]
      start_pe |=> ##1 page_erase_active && op.busy)
      else $error("page erase did not start");
   a_mass_erase_go: assert property ( // [RULE_03]
      start_me |=> state_q == fucc_pkg::FS_MERASE ##1 mass_erase_active)
      else $error("mass erase did not start");
   a_sect_code: assert property ( // [RULE_04] [RULE_07]
      state_q == fucc_pkg::FS_OPEN && cmd_wr &&
      wr_byte == fucc_pkg::CMD_SECT
      |=> code_of(state_q) == fucc_pkg::ST_SECTSEL)
      else $error("sector select code missing");
   a_status_top_zero: assert property ( // [RULE_09]
      s_axi_arvalid && arready_q && rd_idx == fucc_pkg::IDX_CMD
      |=> rvalid_q && rdata_q[7:6] == 2'b00 &&
          rdata_q[5:0] == code_of($past(state_q)))
      else $error("status read wrong");
   a_ps_routing: assert property ( // [RULE_10]
      ps_wr && state_q == fucc_pkg::FS_SECT
      |=> $stable(psel_q) && sect_q == $past(wr_byte))
      else $error("page select write misrouted");
   // Skip the edge after reset; the flop still shows its reset value
   a_page_match: assert property ( // [RULE_11]
      $past(aresetn) |-> hit_q == ($past(prog_addr[15:9]) ==
                                   $past(psel_q[6:0])))
      else $error("page hit decode wrong");
   a_info_map: assert property ( // [RULE_12]
      info_q |-> $past(psel_q[7]) && $past(prog_addr) >= 16'hFE00)
      else $error("info area selected out of range");
   a_bad_cmd_lock: assert property ( // [RULE_19]
      state_q == fucc_pkg::FS_FIRST && cmd_wr &&
      wr_byte != fucc_pkg::CMD_UNLK2 |=> state_q == fucc_pkg::FS_LOCKED)
      else $error("bad command did not lock");
   a_erase_ends: assert property ( // [RULE_20]
      (state_q == fucc_pkg::FS_PERASE || state_q == fucc_pkg::FS_MERASE)
      && op.done |=> code_of(state_q) == fucc_pkg::ST_LOCKED)
      else $error("erase did not leave busy code");
endmodule

// >>> tb/fucc_array_model.sv
// Array-side partner that raises program requests for the controller
`timescale 1ns/10ps
module fucc_array_model (
   input  wire logic        aclk,
   input  wire logic        go,
   input  wire logic [15:0] addr,
   output logic             prog_req,
   output logic [15:0]      prog_addr
);
   // Known levels before the first edge
   initial begin
      prog_req  = 1'b0;
      prog_addr = 16'h0000;
   end

   // One request per go pulse; address is a held level, not a bus
   always @(posedge aclk) begin
      prog_req  <= go;
      prog_addr <= addr;
   end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the flash unlock command controller
`timescale 1ns/10ps
module tb_top;
   localparam logic [15:0] A_CMD = {fucc_pkg::IDX_CMD, 2'b00};
   localparam logic [15:0] A_PS  = {fucc_pkg::IDX_PSEL, 2'b00};
   localparam logic [15:0] A_FH  = {fucc_pkg::IDX_FREQH, 2'b00};
   localparam logic [15:0] A_FL  = {fucc_pkg::IDX_FREQL, 2'b00};
   localparam logic [15:0] A_LOT = {fucc_pkg::IDX_LOT, 2'b00};
   localparam logic [1:0]  OKAY  = fucc_pkg::RESP_OKAY;
   logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [15:0] awaddr = 16'h0000, araddr = 16'h0000, paddr = 16'h0000;
   logic [31:0] wdata = 32'h0, rdata, rd_d;
   logic [1:0]  bresp, rresp, rd_r;
   logic        awready, wready, bvalid, arready, rvalid, prog_req;
   logic        pg_act, pe_act, me_act, phit, isel;
   logic [15:0] prog_addr, freq;
   logic [6:0]  epage;
   logic [7:0]  sprot, ps = 8'h00, sp = 8'h00, fh, fl;
   logic [7:0]  lot [$];
   logic [7:0]  bad [4] = '{8'h95, 8'h63, 8'h5E, 8'h8C};
   logic [7:0]  ers [2] = '{8'h95, 8'h63};
   int          failures = 0, compares = 0, cyc = 0, m_st = 0, seed;

   fucc_top fucc_top_inst (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .prog_req(prog_req), .prog_addr(prog_addr),
      .program_active(pg_act), .page_erase_active(pe_act),
      .mass_erase_active(me_act), .erase_page(epage), .page_hit(phit),
      .info_area_sel(isel), .timing_freq_value(freq), .sector_protect(sprot)
   );

   fucc_array_model fucc_array_model_inst (
      .aclk(aclk), .go(go), .addr(paddr),
      .prog_req(prog_req), .prog_addr(prog_addr)
   );

   // 25 ns period
   always #12.5 aclk = ~aclk;

   // Hang guard, well above the thousand or so cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         close_out;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   // Write with both channels offered together, each released when taken
   task automatic wr(input logic [15:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end while (bvalid !== 1'b1);
      chk(bresp, er);
   endtask

   task automatic rd(input logic [15:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd_d = rdata;
      rd_r = rresp;
   endtask

   task automatic chk_st;
      rd(A_CMD);
      chk(rd_d, 32'(m_st));
   endtask

   // Reference sequencer; commands during a run are dropped
   task automatic cmd(input logic [7:0] c);
      wr(A_CMD, {24'h0, c}, OKAY);
      case (m_st)
         0: m_st = (c == 8'h73) ? 1 : 0;
         1: m_st = (c == 8'h8C) ? 2 : 0;
         2: m_st = (c == 8'h95) ? 16 : (c == 8'h63) ? 32 : 0;
         3, 4: m_st = (c == 8'h5E) ? 4 : 0;
         default: ;
      endcase
      chk_st;
   endtask

   task automatic psw(input logic [7:0] v);
      wr(A_PS, {24'h0, v}, OKAY);
      if (m_st == 4) sp = v;
      else ps = v;
      if (m_st == 2) m_st = 3;
      chk({epage, sprot}, {ps[6:0], sp});
      chk_st;
   endtask

   task automatic poll(input int v);
      do rd(A_CMD); while (rd_d !== 32'(v));
      m_st = v;
   endtask

   task automatic close_out;
      $display("counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      seed = $urandom(32'h337DDFA9);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      bready  <= 1'b1;
      rready  <= 1'b1;
      @(posedge aclk);
      // Reset values and an unmapped place
      chk_st;
      chk({pg_act, pe_act, me_act, isel, epage, sprot}, 32'h0);
      chk(freq, 32'h0);
      rd(16'h0100);
      chk(rd_d, 32'h0);
      chk(32'(rd_r), 32'(fucc_pkg::RESP_SLVERR));
      wr(16'h0100, 32'h5A, fucc_pkg::RESP_SLVERR);
      $display("test reset done");
      // Random frequency bytes, then the slowest legal figure
      repeat (4) begin
         fh = 8'($urandom);
         fl = 8'($urandom);
         wr(A_FH, {24'h0, fh}, OKAY);
         wr(A_FL, {24'h0, fl}, OKAY);
         chk(freq, {fh, fl});
         rd(A_FH);
         chk(rd_d, {24'h0, fh});
      end
      wr(A_FH, 32'h0, OKAY);
      wr(A_FL, 32'h14, OKAY);
      $display("test frequency done");
      // Unlock, decode, sector access and fall back to locked
      cmd(8'h73);
      cmd(8'h8C);
      psw(8'h8A);
      paddr <= 16'h1400;
      repeat (3) @(posedge aclk);
      chk({phit, isel}, 2'b10);
      paddr <= 16'hFE3C;
      repeat (3) @(posedge aclk);
      chk({phit, isel}, 2'b01);
      cmd(8'h5E);
      psw(8'hA5);
      rd(A_PS);
      chk(rd_d, 32'hA5);
      cmd(8'h5E);
      cmd(8'h00);
      psw(8'h0A);
      repeat (3) @(posedge aclk);
      chk(isel, 1'b0);
      $display("test unlock done");
      // Out-of-order codes at the second and third step
      foreach (bad[i]) begin
         cmd(8'h73);
         cmd(bad[i]);
         cmd(8'h73);
         cmd(8'h8C);
         cmd(bad[i] ^ 8'h01);
      end
      $display("test sequence done");
      // Page and mass erase, with a command dropped mid-run
      foreach (ers[i]) begin
         cmd(8'h73);
         cmd(8'h8C);
         cmd(ers[i]);
         chk({me_act, pe_act, pg_act}, m_st[5:3]);
         cmd(8'h73);
         poll(0);
         chk({me_act, pe_act, pg_act}, 3'b000);
      end
      $display("test erase done");
      // Program run from the unlocked state
      cmd(8'h73);
      cmd(8'h8C);
      psw(8'h0A);
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      poll(8);
      chk(pg_act, 1'b1);
      poll(3);
      chk(pg_act, 1'b0);
      $display("test program done");
      // Lot identifier bytes survive a second reset
      for (int i = 0; i < 32; i++) begin
         lot.push_back(8'($urandom));
         wr(A_LOT + 16'(4 * i), {24'h0, lot[i]}, OKAY);
      end
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      m_st = 0;
      @(posedge aclk);
      for (int i = 0; i < 32; i++) begin
         rd(A_LOT + 16'(4 * i));
         chk(rd_d, {24'h0, lot[i]});
      end
      chk_st;
      $display("test lot identifier done");
      close_out;
   end
endmodule
